// ==== core/page_buf.sv ====
// Page buffer: 256 bytes, one write port, one registered read port
`timescale 1ns/100ps
module page_buf
  import spi_flash_pkg::*;
(
  // Clock
  input wire logic clk_sys,
  // Write side, from the serial front end
  input wire logic we,
  input wire logic [7:0] waddr,
  input wire logic [7:0] wdata,
  // Read side, toward the array controller
  input wire logic [7:0] raddr,
  output logic [7:0] rdata
);

  logic [7:0] mem [PAGE_BYTES];

  // ****************************************************************
  // Storage; no reset, contents are only valid after a write
  // ****************************************************************
  always_ff @(posedge clk_sys) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end

endmodule

// ==== core/spi_flash_front.sv ====
// Serial command front end of the flash: framing, decode, addressing, pins
`timescale 1ns/100ps

// Behaviours
module spi_flash_front
  import spi_flash_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // Serial bus from the host
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  output logic dual_out_second_line,
  output logic dual_out_second_line_oe,
  // Serial output pin
  output logic so_out,
  output logic so_oe,
  input wire logic dual_in_second_line,
  // Sector protection state
  input wire logic [SECT_N-1:0] sector_protect,
  // Operation request toward the array controller
  output logic op_start,
  output op_s op_req,
  // Page buffer read port
  input wire logic [7:0] pb_raddr,
  output logic [7:0] pb_rdata,
  // Read data stream
  output logic rd_fetch,
  output logic [19:0] rd_addr,
  input wire logic [7:0] rd_byte
);

  logic [1:0] rst_sync_r;
  logic rst_n;
  fe_s st_r;
  fe_s st_nxt;
  logic rise;
  logic fall;
  logic [7:0] opc_w;
  logic blocked;
  logic [19:0] arr_addr;
  logic [19:0] base_addr;

  // ****************************************************************
  // Reset release through two flops
  // ****************************************************************
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rst_sync_r <= RST_SYNC_INIT;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  // ****************************************************************
  // Edge detection and address helpers
  // ****************************************************************
  // Only edges matter, so the idle clock level of either mode is harmless
  assign rise = sck & ~st_r.sck_q & ~cs_n & ~st_r.cs_q;
  assign fall = ~sck & st_r.sck_q & ~cs_n & ~st_r.cs_q;
  assign opc_w = {st_r.sh[6:0], si};
  assign arr_addr = st_r.addr[ARR_W-1:0];

  // Erase target aligned to its block size
  always_comb begin
    case (st_r.kind)
      K_ERASE_4K: base_addr = arr_addr & ~MASK_4K;
      K_ERASE_32K: base_addr = arr_addr & ~MASK_32K;
      K_ERASE_64K: base_addr = arr_addr & ~MASK_64K;
      K_ERASE_CHIP: base_addr = '0;
      default: base_addr = arr_addr;
    endcase
  end

  // Sector index is simply the top four array bits, ascending
  assign blocked = (st_r.kind == K_ERASE_CHIP) ? (|sector_protect) :
                   sector_protect[arr_addr[ARR_W-1:SECT_LSB]];

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    st_nxt = st_r;
    st_nxt.sck_q = sck;
    st_nxt.cs_q = cs_n;
    st_nxt.op_start = 1'b0;
    st_nxt.rd_fetch = 1'b0;
    st_nxt.pb_we = 1'b0;
    if (cs_n) begin
      // Deselect ends the frame; only a complete frame launches anything
      if (!st_r.cs_q && st_r.state == ST_DIN) begin
        if (st_r.kind inside {K_PROG, K_PROG_DUAL}) begin
          st_nxt.op_start = (st_r.nbytes != 9'h000) && !blocked;
          st_nxt.op.addr = {arr_addr[ARR_W-1:8], st_r.addr[7:0]};
        end else begin
          st_nxt.op_start = !blocked;
          st_nxt.op.addr = base_addr;
        end
        st_nxt.op.kind = st_r.kind;
        st_nxt.op.len = st_r.nbytes;
      end
      st_nxt.state = ST_IDLE;
      st_nxt.so_oe = 1'b0;
      st_nxt.sio_oe = 1'b0;
      st_nxt.cnt = 8'h00;
    end else if (st_r.cs_q) begin
      // Frame opens; the opcode comes first
      st_nxt.state = ST_OPC;
      st_nxt.cnt = 8'h00;
      st_nxt.nbytes = 9'h000;
      st_nxt.bits = BIT_CNT_INIT;
      st_nxt.kind = K_NONE;
    end else if (rise) begin
      if (st_r.cnt != CNT_MAX) begin
        st_nxt.cnt = st_r.cnt + 8'h01;
      end
      case (st_r.state)
        ST_OPC: begin
          st_nxt.sh = opc_w;
          if (st_r.cnt == OPC_LAST_EDGE) begin
            st_nxt.state = ST_ADDR;
            st_nxt.dummy_last = ADDR_LAST_EDGE;
            case (opc_w)
              OPC_READ: st_nxt.kind = K_READ;
              OPC_READ_FAST: begin
                st_nxt.kind = K_READ;
                st_nxt.dummy_last = DUMMY1_LAST_EDGE;
              end
              OPC_READ_MAX: begin
                st_nxt.kind = K_READ;
                st_nxt.dummy_last = DUMMY2_LAST_EDGE;
              end
              OPC_READ_DUAL: begin
                st_nxt.kind = K_READ_DUAL;
                st_nxt.dummy_last = DUMMY1_LAST_EDGE;
              end
              OPC_ERASE_4K: st_nxt.kind = K_ERASE_4K;
              OPC_ERASE_32K: st_nxt.kind = K_ERASE_32K;
              OPC_ERASE_64K: st_nxt.kind = K_ERASE_64K;
              OPC_CHIP_A, OPC_CHIP_B: begin
                st_nxt.kind = K_ERASE_CHIP;
                st_nxt.state = ST_DIN;
              end
              OPC_PROG: st_nxt.kind = K_PROG;
              OPC_PROG_DUAL: st_nxt.kind = K_PROG_DUAL;
              default: st_nxt.state = ST_IGNORE;
            endcase
          end
        end
        ST_ADDR: begin
          st_nxt.addr = {st_r.addr[22:0], si};
          if (st_r.cnt == ADDR_LAST_EDGE) begin
            st_nxt.col = {st_r.addr[6:0], si};
            if (st_r.kind inside {K_READ, K_READ_DUAL}) begin
              if (st_r.dummy_last == ADDR_LAST_EDGE) begin
                st_nxt.state = ST_DOUT;
                st_nxt.rd_fetch = 1'b1;
                st_nxt.rd_addr = {st_r.addr[18:0], si};
                st_nxt.bits = BIT_CNT_INIT;
              end else begin
                st_nxt.state = ST_DUMMY;
              end
            end else begin
              st_nxt.state = ST_DIN;
            end
          end
        end
        ST_DUMMY: begin
          if (st_r.cnt == st_r.dummy_last) begin
            st_nxt.state = ST_DOUT;
            st_nxt.rd_fetch = 1'b1;
            st_nxt.rd_addr = arr_addr;
            st_nxt.bits = BIT_CNT_INIT;
          end
        end
        ST_DIN: begin
          // Data bytes only matter to the program commands
          if (st_r.kind == K_PROG_DUAL) begin
            st_nxt.sh = {st_r.sh[5:0], dual_in_second_line, si};
            st_nxt.bits = st_r.bits + 3'h2;
          end else begin
            st_nxt.sh = opc_w;
            st_nxt.bits = st_r.bits + 3'h1;
          end
          if ((st_r.kind == K_PROG && st_r.bits == 3'h7) ||
              (st_r.kind == K_PROG_DUAL && st_r.bits == 3'h6)) begin
            // Column wraps inside the page; later bytes overwrite earlier
            st_nxt.pb_we = 1'b1;
            st_nxt.pb_waddr = st_r.col;
            st_nxt.pb_wdata = (st_r.kind == K_PROG_DUAL) ?
                              {st_r.sh[5:0], dual_in_second_line, si} : opc_w;
            st_nxt.col = st_r.col + 8'h01;
            if (st_r.nbytes != PAGE_BYTES) begin
              st_nxt.nbytes = st_r.nbytes + 9'h001;
            end
          end
        end
        default: begin
          st_nxt.state = st_r.state;
        end
      endcase
    end else if (fall && st_r.state == ST_DOUT) begin
      if (st_r.bits == BIT_CNT_INIT) begin
        // New byte: load it and fetch the following one ahead of time
        st_nxt.rd_addr = st_r.rd_addr + 20'h00001;
        st_nxt.rd_fetch = 1'b1;
        st_nxt.so_oe = 1'b1;
        st_nxt.so_out = rd_byte[7];
        if (st_r.kind == K_READ_DUAL) begin
          st_nxt.sio_oe = 1'b1;
          st_nxt.sio_out = rd_byte[6];
          st_nxt.tx = {rd_byte[5:0], 2'b00};
          st_nxt.bits = 3'h3;
        end else begin
          st_nxt.tx = {rd_byte[6:0], 1'b0};
          st_nxt.bits = 3'h7;
        end
      end else begin
        st_nxt.so_out = st_r.tx[7];
        if (st_r.kind == K_READ_DUAL) begin
          st_nxt.sio_out = st_r.tx[6];
          st_nxt.tx = {st_r.tx[5:0], 2'b00};
        end else begin
          st_nxt.tx = {st_r.tx[6:0], 1'b0};
        end
        st_nxt.bits = st_r.bits - 3'h1;
      end
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
      st_r.state <= ST_IDLE;
      st_r.sck_q <= 1'b0;
      st_r.cs_q <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ****************************************************************
  // Page buffer and outputs
  // ****************************************************************
  page_buf u_page_buf (
    .clk_sys(clk_sys),
    .we(st_r.pb_we),
    .waddr(st_r.pb_waddr),
    .wdata(st_r.pb_wdata),
    .raddr(pb_raddr),
    .rdata(pb_rdata)
  );

  assign so_out = st_r.so_out;
  assign so_oe = st_r.so_oe;
  assign dual_out_second_line = st_r.sio_out;
  assign dual_out_second_line_oe = st_r.sio_oe;
  assign op_start = st_r.op_start;
  assign op_req = st_r.op;
  assign rd_fetch = st_r.rd_fetch;
  assign rd_addr = st_r.rd_addr;

  // ****************************************************************
  // Checks
  // ****************************************************************
  property p_hiz_deselect;
    @(posedge clk_sys) disable iff (!rst_n)
    cs_n |=> !so_oe && !dual_out_second_line_oe;
  endproperty
  a_hiz_deselect: assert property (p_hiz_deselect)
    else $error("output driven while deselected");

  property p_ignore_holds;
    @(posedge clk_sys) disable iff (!rst_n)
    (st_r.state == ST_IGNORE) && !cs_n |=> (st_r.state == ST_IGNORE) && !op_start && !so_oe;
  endproperty
  a_ignore_holds: assert property (p_ignore_holds)
    else $error("unsupported opcode left the ignore state");

  property p_abort_addr;
    @(posedge clk_sys) disable iff (!rst_n)
    cs_n && !st_r.cs_q && (st_r.state inside {ST_OPC, ST_ADDR}) |=> !op_start ##1 st_r.state == ST_IDLE;
  endproperty
  a_abort_addr: assert property (p_abort_addr)
    else $error("incomplete frame launched an operation");

  property p_erase64_align;
    @(posedge clk_sys) disable iff (!rst_n)
    op_start && op_req.kind == K_ERASE_64K |-> op_req.addr[15:0] == 16'h0000;
  endproperty
  a_erase64_align: assert property (p_erase64_align)
    else $error("64K erase address not aligned");

  property p_cnt_step;
    @(posedge clk_sys) disable iff (!rst_n)
    rise && st_r.cnt != CNT_MAX |=> st_r.cnt == $past(st_r.cnt) + 8'h01;
  endproperty
  a_cnt_step: assert property (p_cnt_step)
    else $error("edge counter did not advance");

  property p_opc_end;
    @(posedge clk_sys) disable iff (!rst_n)
    rise && st_r.state == ST_OPC && st_r.cnt == OPC_LAST_EDGE |=> st_r.state != ST_OPC;
  endproperty
  a_opc_end: assert property (p_opc_end)
    else $error("opcode phase longer than eight edges");

  property p_addr_shift;
    @(posedge clk_sys) disable iff (!rst_n)
    rise && st_r.state == ST_ADDR |=> st_r.addr[0] == $past(si);
  endproperty
  a_addr_shift: assert property (p_addr_shift)
    else $error("address bit not taken on the rising edge");

  property p_dual_pins;
    @(posedge clk_sys) disable iff (!rst_n)
    dual_out_second_line_oe |-> st_r.kind == K_READ_DUAL && st_r.state == ST_DOUT;
  endproperty
  a_dual_pins: assert property (p_dual_pins)
    else $error("second line driven outside dual read");

  property p_msb_first;
    @(posedge clk_sys) disable iff (!rst_n)
    fall && st_r.state == ST_DOUT && st_r.bits == BIT_CNT_INIT |=> so_out == $past(rd_byte[7]);
  endproperty
  a_msb_first: assert property (p_msb_first)
    else $error("read byte not sent MSB first");

  property p_no_prog_len_zero;
    @(posedge clk_sys) disable iff (!rst_n)
    op_start && (op_req.kind inside {K_PROG, K_PROG_DUAL}) |-> op_req.len != 9'h000 && op_req.len <= PAGE_BYTES;
  endproperty
  a_no_prog_len_zero: assert property (p_no_prog_len_zero)
    else $error("program length outside 1 to 256");

endmodule

// ==== core/spi_flash_pkg.sv ====
// Shared constants, states and carriers of the serial flash command front end
package spi_flash_pkg;

  // ****************************************************************
  // Opcodes
  // ****************************************************************
  localparam logic [7:0] OPC_READ = 8'h03;
  localparam logic [7:0] OPC_READ_FAST = 8'h0b;
  localparam logic [7:0] OPC_READ_MAX = 8'h1b;
  localparam logic [7:0] OPC_READ_DUAL = 8'h3b;
  localparam logic [7:0] OPC_ERASE_4K = 8'h20;
  localparam logic [7:0] OPC_ERASE_32K = 8'h52;
  localparam logic [7:0] OPC_ERASE_64K = 8'hd8;
  localparam logic [7:0] OPC_CHIP_A = 8'h60;
  localparam logic [7:0] OPC_CHIP_B = 8'hc7;
  localparam logic [7:0] OPC_PROG = 8'h02;
  localparam logic [7:0] OPC_PROG_DUAL = 8'ha2;

  // ****************************************************************
  // Frame positions, counted in rising serial clock edges
  // ****************************************************************
  localparam logic [7:0] OPC_LAST_EDGE = 8'h07;
  localparam logic [7:0] ADDR_LAST_EDGE = 8'h1f;
  localparam logic [7:0] DUMMY1_LAST_EDGE = 8'h27;
  localparam logic [7:0] DUMMY2_LAST_EDGE = 8'h2f;
  localparam logic [7:0] CNT_MAX = 8'hff;

  // ****************************************************************
  // Array geometry
  // ****************************************************************
  localparam int ARR_W = 20;
  localparam int SECT_LSB = 16;
  localparam int SECT_N = 16;
  localparam logic [19:0] MASK_4K = 20'h00fff;
  localparam logic [19:0] MASK_32K = 20'h07fff;
  localparam logic [19:0] MASK_64K = 20'h0ffff;
  localparam logic [8:0] PAGE_BYTES = 9'h100;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [1:0] RST_SYNC_INIT = 2'h0;
  localparam logic [2:0] BIT_CNT_INIT = 3'h0;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_OPC = 7'h02,
    ST_ADDR = 7'h04,
    ST_DUMMY = 7'h08,
    ST_DIN = 7'h10,
    ST_DOUT = 7'h20,
    ST_IGNORE = 7'h40
  } fsm_e;

  typedef enum logic [3:0] {
    K_NONE = 4'h0,
    K_ERASE_4K = 4'h1,
    K_ERASE_32K = 4'h2,
    K_ERASE_64K = 4'h3,
    K_ERASE_CHIP = 4'h4,
    K_PROG = 4'h5,
    K_PROG_DUAL = 4'h6,
    K_READ = 4'h7,
    K_READ_DUAL = 4'h8
  } kind_e;

  // Operation handed to the self-timed array controller
  typedef struct packed {
    kind_e kind;
    logic [19:0] addr;
    logic [8:0] len;
  } op_s;

  // Complete front end state
  typedef struct packed {
    fsm_e state;
    kind_e kind;
    logic sck_q;
    logic cs_q;
    logic [7:0] cnt;
    logic [7:0] sh;
    logic [23:0] addr;
    logic [7:0] dummy_last;
    logic [7:0] col;
    logic [8:0] nbytes;
    logic [2:0] bits;
    logic [7:0] tx;
    logic so_out;
    logic so_oe;
    logic sio_out;
    logic sio_oe;
    logic op_start;
    op_s op;
    logic rd_fetch;
    logic [19:0] rd_addr;
    logic pb_we;
    logic [7:0] pb_waddr;
    logic [7:0] pb_wdata;
  } fe_s;

endpackage

// ==== testbench/spi_host_model.sv ====
// SPI host model: frames commands toward the flash front end, mode 0 or 3
`timescale 1ns/100ps
module spi_host_model (
  // Clock
  input wire logic clk_sys,
  // Host side of the serial bus
  output logic cs_n,
  output logic sck,
  output logic si_drv,
  output logic si_en,
  output logic so_drv,
  output logic so_en,
  // Resolved pin levels
  input wire logic si_pin,
  input wire logic so_pin
);
  logic mode3;

  // ****************************************************************
  // Idle bus at time zero
  // ****************************************************************
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    si_drv = 1'b0;
    si_en = 1'b0;
    so_drv = 1'b0;
    so_en = 1'b0;
    mode3 = 1'b0;
  end

  // Every change lands just after a system clock edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #2;
  endtask

  // Idle clock level picks the mode, then select opens the frame
  task automatic open(input logic m3);
    mode3 = m3;
    sck = m3;
    tick(2);
    cs_n = 1'b0;
    si_en = 1'b1;
    tick(3);
  endtask

  // One byte; dm 0 single, 1 dual sent by host, 2 dual received
  task automatic xfer(input logic [7:0] tx, input int dm, output logic [7:0] rx);
    int nb;
    nb = (dm == 0) ? 8 : 4;
    rx = 8'h00;
    so_en = (dm == 1);
    si_en = (dm != 2);
    for (int i = 0; i < nb; i++) begin
      sck = 1'b0;
      if (dm == 0) begin
        si_drv = tx[7-i];
      end else begin
        so_drv = tx[7-2*i];
        si_drv = tx[6-2*i];
      end
      tick(4);
      sck = 1'b1;
      if (dm == 0) begin
        rx = {rx[6:0], so_pin};
      end else begin
        rx = {rx[5:0], so_pin, si_pin};
      end
      tick(4);
    end
  endtask

  // Mode 0 parks the clock low before deselecting
  task automatic close();
    if (!mode3) begin
      sck = 1'b0;
      tick(4);
    end
    cs_n = 1'b1;
    si_en = 1'b0;
    so_en = 1'b0;
    tick(4);
  endtask
endmodule

// ==== testbench/tb_spi_flash_command_front_end.sv ====
// Self-checking bench for the serial flash command front end
`timescale 1ns/100ps
module tb_spi_flash_command_front_end import spi_flash_pkg::*; ;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic cs_n, sck, si_drv, si_en, so_drv, so_en, si_pin, so_pin;
  logic junk = 1'b0;
  logic dual_out_second_line, dual_out_second_line_oe, so_out, so_oe;
  logic [SECT_N-1:0] sector_protect = '0;
  logic op_start, rd_fetch;
  op_s op_req;
  op_s last_op;
  logic [7:0] pb_raddr = 8'h00;
  logic [7:0] pb_rdata;
  logic [19:0] rd_addr;
  logic [7:0] rd_byte = 8'h00;
  int n_oe = 0;
  int fail_count = 0;
  int n_checks = 0;
  int n_ops = 0;

  // ****************************************************************
  // Clock, pins and back end models
  // ****************************************************************
  initial begin
    forever #10 clk_sys = ~clk_sys;
  end

  // Undriven pins wander, so a stale bit never passes for data
  always @(posedge clk_sys) junk <= ~junk;
  assign si_pin = dual_out_second_line_oe ? dual_out_second_line : (si_en ? si_drv : junk);
  assign so_pin = so_oe ? so_out : (so_en ? so_drv : ~junk);

  function automatic logic [7:0] arr(input logic [19:0] a);
    return a[7:0] + a[19:12];
  endfunction

  // Array stand-in answers each fetch on the next edge
  always @(posedge clk_sys) begin
    if (rd_fetch === 1'b1) rd_byte <= arr(rd_addr);
    if (op_start === 1'b1) begin
      n_ops++;
      last_op = op_req;
    end
    if (so_oe === 1'b1 || dual_out_second_line_oe === 1'b1) n_oe++;
  end

  spi_host_model host (
    .clk_sys(clk_sys), .cs_n(cs_n), .sck(sck), .si_drv(si_drv), .si_en(si_en),
    .so_drv(so_drv), .so_en(so_en), .si_pin(si_pin), .so_pin(so_pin)
  );

  spi_flash_front dut (
    .clk_sys(clk_sys), .arst_n(arst_n), .cs_n(cs_n), .sck(sck), .si(si_pin),
    .dual_out_second_line(dual_out_second_line),
    .dual_out_second_line_oe(dual_out_second_line_oe),
    .so_out(so_out), .so_oe(so_oe), .dual_in_second_line(so_pin),
    .sector_protect(sector_protect), .op_start(op_start), .op_req(op_req),
    .pb_raddr(pb_raddr), .pb_rdata(pb_rdata), .rd_fetch(rd_fetch),
    .rd_addr(rd_addr), .rd_byte(rd_byte)
  );

  // ****************************************************************
  // Compare and helper tasks
  // ****************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  // Exactly one launch since n0, with the given fields
  task automatic chk_op(input int n0, input logic [3:0] k, input logic [19:0] a,
                        input logic [8:0] l);
    chk(32'(n_ops - n0), 32'h1);
    chk(32'(last_op.kind), 32'(k));
    chk(32'(last_op.addr), 32'(a));
    chk(32'(last_op.len), 32'(l));
  endtask

  // Whole frame: opcode, na address bytes, nd data bytes of d (top byte first) in mode dm
  task automatic cmd(input logic [7:0] opc, input logic [23:0] a, input int na,
                     input int dm, input logic [31:0] d, input int nd);
    logic [7:0] rx;
    host.open(1'b0);
    host.xfer(opc, 0, rx);
    for (int i = 0; i < na; i++) host.xfer(a[23-8*i -: 8], 0, rx);
    for (int i = 0; i < nd; i++) host.xfer(d[31-8*i -: 8], dm, rx);
    host.close();
  endtask

  task automatic complete_run();
    if (fail_count == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  // Every read flavour, top nibble set, reading across the array end
  task automatic t_read();
    logic [7:0] rx;
    logic [7:0] opc [4] = '{OPC_READ, OPC_READ_FAST, OPC_READ_MAX, OPC_READ_DUAL};
    int nd [4] = '{0, 1, 2, 1};
    for (int k = 0; k < 4; k++) begin
      host.open(k == 1);
      host.xfer(opc[k], 0, rx);
      host.xfer(8'hbf, 0, rx);
      host.xfer(8'hff, 0, rx);
      host.xfer(8'hfe, 0, rx);
      for (int j = 0; j < nd[k]; j++) host.xfer(8'h00, 0, rx);
      for (int b = 0; b < 3; b++) begin
        host.xfer(8'h00, (k == 3) ? 2 : 0, rx);
        chk(32'(rx), 32'(arr(20'hffffe + 20'(b))));
      end
      host.close();
      chk(32'({so_oe, dual_out_second_line_oe}), 32'h0);
    end
  endtask

  // Block sizes, chip erase, and a protected top sector
  task automatic t_erase();
    int n0;
    logic [7:0] opc [3] = '{OPC_ERASE_4K, OPC_ERASE_32K, OPC_ERASE_64K};
    logic [19:0] base [3] = '{20'had000, 20'ha8000, 20'ha0000};
    for (int k = 0; k < 3; k++) begin
      n0 = n_ops;
      cmd(opc[k], 24'h3ad678, 3, 0, 32'h0, 0);
      chk_op(n0, 4'(k + 1), base[k], 9'h000);
    end
    for (int k = 0; k < 2; k++) begin
      n0 = n_ops;
      cmd(k ? OPC_CHIP_B : OPC_CHIP_A, 24'h0, 0, 0, 32'h0, 0);
      chk(32'(last_op.kind), 32'(K_ERASE_CHIP));
      chk(32'(n_ops - n0), 32'h1);
    end
    sector_protect = 16'h8000;
    n0 = n_ops;
    cmd(OPC_ERASE_4K, 24'h0f1234, 3, 0, 32'h0, 0);
    cmd(OPC_CHIP_A, 24'h0, 0, 0, 32'h0, 0);
    chk(32'(n_ops - n0), 32'h0);
    cmd(OPC_ERASE_64K, 24'h0effff, 3, 0, 32'h0, 0);
    chk_op(n0, 4'(K_ERASE_64K), 20'he0000, 9'h000);
    sector_protect = '0;
  endtask

  // Page program wrapping in its page, then dual-input program
  task automatic t_prog();
    int n0;
    logic [7:0] col [5] = '{8'hfe, 8'hff, 8'h00, 8'h10, 8'h11};
    logic [7:0] val [5] = '{8'ha1, 8'hb2, 8'hc3, 8'h5c, 8'h96};
    n0 = n_ops;
    cmd(OPC_PROG, 24'h1234fe, 3, 0, 32'ha1b2c300, 3);
    chk_op(n0, 4'(K_PROG), 20'h234fe, 9'h003);
    n0 = n_ops;
    cmd(OPC_PROG_DUAL, 24'h000010, 3, 1, 32'h5c960000, 2);
    chk_op(n0, 4'(K_PROG_DUAL), 20'h00010, 9'h002);
    for (int i = 0; i < 5; i++) begin
      pb_raddr = col[i];
      host.tick(1);
      chk(32'(pb_rdata), 32'(val[i]));
    end
  endtask

  // Unknown opcode swallows an erase-like tail; early deselect aborts
  task automatic t_refuse();
    int n0;
    int o0;
    n0 = n_ops;
    o0 = n_oe;
    cmd(8'h9f, 24'h0, 0, 0, {OPC_ERASE_4K, 24'h001000}, 4);
    chk(32'(n_ops - n0), 32'h0);
    chk(32'(n_oe - o0), 32'h0);
    cmd(OPC_ERASE_4K, 24'h002000, 2, 0, 32'h0, 0);
    chk(32'(n_ops - n0), 32'h0);
    cmd(OPC_ERASE_4K, 24'h001000, 3, 0, 32'h0, 0);
    chk_op(n0, 4'(K_ERASE_4K), 20'h01000, 9'h000);
  endtask

  // ****************************************************************
  // Main sequence and watchdog
  // ****************************************************************
  initial begin
    repeat (2) @(posedge clk_sys);
    #2;
    arst_n = 1'b1;
    host.tick(4);
    chk(32'({so_oe, dual_out_second_line_oe, op_start, rd_fetch}), 32'h0);
    t_read();
    t_erase();
    t_prog();
    t_refuse();
    complete_run();
  end

  // About 5200 cycles expected; allow several times that
  initial begin
    #800000;
    fail_count++;
    complete_run();
  end
endmodule
